// ==== sensor_readout_pkg.sv ====
// Shared constants, carriers and state types for the motion and image readout block
package sensor_readout_pkg;

    // Register addresses
    localparam logic [6:0] ADDR_MOTION_STATUS   = 7'h02;
    localparam logic [6:0] ADDR_X_DISPLACEMENT  = 7'h03;
    localparam logic [6:0] ADDR_Y_DISPLACEMENT  = 7'h04;
    localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h05;
    localparam logic [6:0] ADDR_EXPOSURE_HIGH   = 7'h06;
    localparam logic [6:0] ADDR_EXPOSURE_LOW    = 7'h07;
    localparam logic [6:0] ADDR_BRIGHTEST       = 7'h08;
    localparam logic [6:0] ADDR_BRIGHTNESS_SUM  = 7'h09;
    localparam logic [6:0] ADDR_DARKEST         = 7'h0a;
    localparam logic [6:0] ADDR_CAPTURE_PORT    = 7'h0b;
    localparam logic [6:0] ADDR_CHIP_RESET      = 7'h3a;

    // Field positions and values
    localparam logic [7:0] CHIP_RESET_KEY    = 8'h5a;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam int         MOVEMENT_FLAG_BIT = 7;
    localparam int         GRAB_VALID_BIT    = 7;
    localparam int         SUM_MSB           = 14;
    localparam int         SUM_LSB           = 7;
    localparam logic [7:0] QUALITY_MAX       = 8'h90;
    localparam logic [7:0] LAST_PIXEL        = 8'he0;

    // Exposure control
    localparam logic [15:0] SHUTTER_RESET = 16'h0000;
    localparam logic [15:0] SHUTTER_STEP  = 16'h0010;
    localparam logic [6:0]  BRIGHT_HIGH   = 7'h64;
    localparam logic [6:0]  BRIGHT_LOW    = 7'h28;
    localparam logic [7:0]  SUM_HIGH      = 8'hbe;

    // Serial frame layout
    localparam logic [4:0] SPI_CMD_BITS   = 5'h08;
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    localparam int         SPI_WRITE_BIT  = 15;
    localparam int         PIN_NCS        = 0;
    localparam int         PIN_SCLK       = 1;
    localparam int         PIN_MOSI       = 2;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic              valid;
        logic signed [7:0] dx;
        logic signed [7:0] dy;
        logic [8:0]        features;
    } frame_result_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic [6:0] value;
    } pixel_t;

    typedef struct packed {
        logic [2:0][2:0] sy;
        logic [2:0]      pin_f;
        logic [4:0]      bitcnt;
        logic [15:0]     shin;
        logic [7:0]      shout;
        logic [1:0]      pend;
        logic            miso;
        reg_req_t        req;
    } spi_state_t;

    typedef struct packed {
        logic [2:0]        rst_sy;
        logic              rst_pin_f;
        logic              rst_all;
        logic              movement_flag;
        logic signed [7:0] dx;
        logic signed [7:0] dy;
        logic [7:0]        quality;
        logic [15:0]       shutter;
        logic [7:0]        shut_lo;
        logic [6:0]        maxp;
        logic [6:0]        minp;
        logic [7:0]        sum_reg;
        logic [6:0]        cur_max;
        logic [6:0]        cur_min;
        logic [14:0]       acc;
        logic [7:0]        pix_idx;
        logic [7:0]        grab_cnt;
        logic              grab_valid;
        logic              grab_done;
        logic [6:0]        grab_pix;
        logic [7:0]        rdata;
    } readout_state_t;

endpackage

// ==== serial_reg_port.sv ====
// Four-wire serial slave that turns pin traffic into register read and write requests
`timescale 1ns/1ps
`default_nettype none
module serial_reg_port
    import sensor_readout_pkg::*;
(
    input  wire logic     i_core_clk,
    input  wire logic     i_srst,
    input  wire logic     i_ncs_n,
    input  wire logic     i_sclk,
    input  wire logic     i_mosi,
    input  wire logic [7:0] i_rdata,
    output logic          o_miso,
    output reg_req_t      o_req
);
    spi_state_t q;
    spi_state_t d;
    logic [2:0] pins;
    logic [2:0] f_n;
    logic       rise;
    logic [15:0] sh_n;

    assign pins = {i_mosi, i_sclk, i_ncs_n};

    always_comb begin
        d = q;
        d.req.rd = 1'b0;
        d.req.wr = 1'b0;
        f_n = q.pin_f;
        for (int i = 0; i < 3; i++) begin
            d.sy[i] = {q.sy[i][1:0], pins[i]};
            // Only the settled second and third stages are trusted
            if (q.sy[i][1] == q.sy[i][2]) begin
                f_n[i] = q.sy[i][2];
            end
        end
        d.pin_f = f_n;
        rise = f_n[PIN_SCLK] & ~q.pin_f[PIN_SCLK];
        sh_n = {q.shin[14:0], f_n[PIN_MOSI]};
        d.pend = {q.pend[0], 1'b0};
        if (q.pend[1]) begin
            d.shout = i_rdata;
        end
        if (f_n[PIN_NCS]) begin
            d.bitcnt = 5'h00;
            d.pend = 2'b00;
        end else if (rise && q.bitcnt < SPI_FRAME_BITS) begin
            d.shin = sh_n;
            d.bitcnt = q.bitcnt + 5'h01;
            if (q.bitcnt >= SPI_CMD_BITS) begin
                d.shout = {q.shout[6:0], 1'b0};
            end
            if (q.bitcnt == SPI_CMD_BITS - 5'h01 && !sh_n[7]) begin
                d.req.rd = 1'b1;
                d.req.addr = sh_n[6:0];
                d.pend = 2'b01;
            end
            if (q.bitcnt == SPI_FRAME_BITS - 5'h01 && sh_n[SPI_WRITE_BIT]) begin
                d.req.wr = 1'b1;
                d.req.addr = sh_n[14:8];
                d.req.wdata = sh_n[7:0];
            end
        end
        d.miso = f_n[PIN_NCS] ? 1'b0 : d.shout[7];
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            q <= '0;
            // Chip select and clock rest high, so no false edge after reset
            q.pin_f <= 3'b011;
            q.sy <= {3'b000, 3'b111, 3'b111};
        end else begin
            q <= d;
        end
    end

    assign o_miso = q.miso;
    assign o_req = q.req;
endmodule
`default_nettype wire

// ==== motion_and_image_readout_regs.sv ====
// Motion, exposure, frame statistics and image grabber registers behind the serial port
//
// Overview of operation
// - Movement flag lives in bit 7 of the motion status register.
// - Flag reads 0 without motion, 1 when displacement data waits.
// - Any write to motion status clears flag and both displacements, data dropped.
// - X displacement is signed 8-bit, resolution scaled, cleared by its read.
// - Y displacement is signed 8-bit, resolution scaled, cleared by its read.
// - Surface quality reports upper 8 of 9-bit feature count, never above 144.
// - Exposure is a 16-bit cycle count split over high and low bytes.
// - Exposure adjusts itself to keep brightness in range.
// - Brightest pixel of each frame reported, 0 to 127.
// - Darkest pixel of each frame reported, 0 to 127.
// - Pixel sum kept in 15 bits; register shows bits 14 to 7.
// - Grabber takes at most one pixel per frame at its counter position.
// - Valid grab read returns pixel with bit 7 set and advances counter.
// - Any grab write resets counter and waits for pixel 0 of next image.
// - Reset pin low or 0x5a to chip reset performs full reset.
`timescale 1ns/1ps
`default_nettype none
module motion_and_image_readout_regs
    import sensor_readout_pkg::*;
(
    input  wire logic          i_core_clk,
    input  wire logic          i_srst,
    input  wire logic          i_hardware_reset_pin_n,
    input  wire logic          i_ncs_n,
    input  wire logic          i_sclk,
    input  wire logic          i_mosi,
    input  wire logic          i_res_high,
    input  wire frame_result_t i_frame,
    input  wire pixel_t        i_pix,
    output logic               o_miso,
    output logic [15:0]        o_exposure
);
    readout_state_t q;
    readout_state_t d;
    reg_req_t       req;
    logic           port_rst;

    logic signed [7:0] dxs;
    logic signed [7:0] dys;
    logic [7:0]  idx;
    logic [6:0]  nmax;
    logic [6:0]  nmin;
    logic [14:0] nacc;
    logic        done_now;
    logic        rd_of;
    logic        wr_of;

    // Add with clamp to the signed 8-bit range
    function automatic logic signed [7:0] sat_add(input logic signed [7:0] a,
                                                  input logic signed [7:0] b);
        logic signed [8:0] s;
        s = {a[7], a} + {b[7], b};
        if (s > 9'sd127) begin
            sat_add = 8'sh7f;
        end else if (s < -9'sd128) begin
            sat_add = 8'sh80;
        end else begin
            sat_add = s[7:0];
        end
    endfunction

    // Step the exposure toward the bright or dark side, saturating at both ends
    function automatic logic [15:0] exposure_step(input logic [15:0] sh,
                                                  input logic [6:0]  mx,
                                                  input logic [7:0]  sm);
        logic [16:0] up;
        up = {1'b0, sh} + {1'b0, SHUTTER_STEP};
        exposure_step = sh;
        if (mx > BRIGHT_HIGH || sm > SUM_HIGH) begin
            exposure_step = (sh > SHUTTER_STEP) ? sh - SHUTTER_STEP : SHUTTER_RESET;
        end else if (mx < BRIGHT_LOW) begin
            exposure_step = up[16] ? 16'hffff : up[15:0];
        end
    endfunction

    serial_reg_port serial_reg_port_inst (
        .i_core_clk (i_core_clk),
        .i_srst     (port_rst),
        .i_ncs_n    (i_ncs_n),
        .i_sclk     (i_sclk),
        .i_mosi     (i_mosi),
        .i_rdata    (q.rdata),
        .o_miso     (o_miso),
        .o_req      (req)
    );

    assign port_rst = i_srst | q.rst_all;

    function automatic logic hit(input reg_req_t r, input logic [6:0] a);
        hit = (r.addr == a);
    endfunction

    always_comb begin
        d = q;
        rd_of = 1'b0;
        wr_of = 1'b0;

        // Resolution: low setting reports half the counts
        dxs = i_res_high ? i_frame.dx : (i_frame.dx >>> 1);
        dys = i_res_high ? i_frame.dy : (i_frame.dy >>> 1);

        // Motion flag and displacements; a new frame wins over a clear
        if ((req.rd || req.wr) && hit(req, ADDR_MOTION_STATUS)) begin
            d.movement_flag = 1'b0;
        end
        if ((req.rd && hit(req, ADDR_X_DISPLACEMENT)) ||
            (req.wr && hit(req, ADDR_MOTION_STATUS))) begin
            d.dx = 8'sh00;
        end
        if ((req.rd && hit(req, ADDR_Y_DISPLACEMENT)) ||
            (req.wr && hit(req, ADDR_MOTION_STATUS))) begin
            d.dy = 8'sh00;
        end
        if (i_frame.valid) begin
            d.dx = sat_add(d.dx, dxs);
            d.dy = sat_add(d.dy, dys);
            if (dxs != 8'sh00 || dys != 8'sh00) begin
                d.movement_flag = 1'b1;
            end
            d.quality = (i_frame.features[8:1] > QUALITY_MAX) ?
                        QUALITY_MAX : i_frame.features[8:1];
        end

        // Per-frame pixel statistics
        idx = i_pix.first ? 8'h00 : q.pix_idx;
        done_now = i_pix.first ? 1'b0 : q.grab_done;
        nmax = (i_pix.first || i_pix.value > q.cur_max) ? i_pix.value : q.cur_max;
        nmin = (i_pix.first || i_pix.value < q.cur_min) ? i_pix.value : q.cur_min;
        nacc = (i_pix.first ? 15'h0000 : q.acc) + {8'h00, i_pix.value};
        if (i_pix.valid) begin
            d.cur_max = nmax;
            d.cur_min = nmin;
            d.acc = nacc;
            d.pix_idx = idx + 8'h01;
            d.grab_done = done_now;
            if (idx == LAST_PIXEL) begin
                d.maxp = nmax;
                d.minp = nmin;
                d.sum_reg = nacc[SUM_MSB:SUM_LSB];
                d.shutter = exposure_step(q.shutter, nmax,
                                          nacc[SUM_MSB:SUM_LSB]);
            end
            // One capture per frame: the done flag only drops at frame start
            if (!q.grab_valid && !done_now && idx == q.grab_cnt) begin
                d.grab_valid = 1'b1;
                d.grab_pix = i_pix.value;
                d.grab_done = 1'b1;
            end
        end

        // Register reads and their side effects
        if (req.rd) begin
            case (req.addr)
                ADDR_MOTION_STATUS: begin
                    d.rdata = REG_RESET;
                    d.rdata[MOVEMENT_FLAG_BIT] = q.movement_flag;
                end
                ADDR_X_DISPLACEMENT:  d.rdata = q.dx;
                ADDR_Y_DISPLACEMENT:  d.rdata = q.dy;
                ADDR_SURFACE_QUALITY: d.rdata = q.quality;
                ADDR_EXPOSURE_HIGH: begin
                    // Low byte frozen here so the pair stays coherent
                    d.rdata = q.shutter[15:8];
                    d.shut_lo = q.shutter[7:0];
                end
                ADDR_EXPOSURE_LOW:    d.rdata = q.shut_lo;
                ADDR_BRIGHTEST:       d.rdata = {1'b0, q.maxp};
                ADDR_BRIGHTNESS_SUM:  d.rdata = q.sum_reg;
                ADDR_DARKEST:         d.rdata = {1'b0, q.minp};
                ADDR_CAPTURE_PORT: begin
                    rd_of = 1'b1;
                    d.rdata = {q.grab_valid, q.grab_pix};
                    if (q.grab_valid) begin
                        d.grab_valid = 1'b0;
                        d.grab_cnt = (q.grab_cnt == LAST_PIXEL) ?
                                     8'h00 : q.grab_cnt + 8'h01;
                    end
                end
                default:              d.rdata = REG_RESET;
            endcase
        end

        // Register writes; only the capture port address reacts here
        if (req.wr) begin
            case (req.addr)
                ADDR_CAPTURE_PORT: begin
                    wr_of = 1'b1;
                    d.grab_cnt = 8'h00;
                    d.grab_valid = 1'b0;
                    d.grab_done = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Reset pin synchroniser and full reset request
        d.rst_sy = {q.rst_sy[1:0], i_hardware_reset_pin_n};
        if (q.rst_sy[1] == q.rst_sy[2]) begin
            d.rst_pin_f = q.rst_sy[2];
        end
        d.rst_all = ~d.rst_pin_f |
                    (req.wr && hit(req, ADDR_CHIP_RESET) &&
                     req.wdata == CHIP_RESET_KEY);
        if (q.rst_all) begin
            d = '0;
            d.shutter = SHUTTER_RESET;
            d.rst_sy = {q.rst_sy[1:0], i_hardware_reset_pin_n};
            d.rst_pin_f = (q.rst_sy[1] == q.rst_sy[2]) ? q.rst_sy[2] : q.rst_pin_f;
            d.rst_all = ~d.rst_pin_f;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            q <= '0;
            q.shutter <= SHUTTER_RESET;
            q.rst_sy <= 3'b111;
            q.rst_pin_f <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_exposure = q.shutter;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // Motion flag, displacement, quality, sum, grabber and chip reset side effects
    property p_flag_set;
        i_frame.valid && (i_frame.dx != 8'sh00 || i_frame.dy != 8'sh00) &&
        i_res_high && !q.rst_all |=> q.movement_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("movement flag not set");

    property p_flag_wr_clear;
        req.wr && req.addr == ADDR_MOTION_STATUS && !i_frame.valid
        |=> !q.movement_flag && q.dx == 8'sh00 && q.dy == 8'sh00;
    endproperty
    a_flag_wr_clear: assert property (p_flag_wr_clear) else $error("write clear lost");

    property p_flag_rd_clear;
        req.rd && req.addr == ADDR_MOTION_STATUS && !i_frame.valid && !q.rst_all
        |=> !q.movement_flag;
    endproperty
    a_flag_rd_clear: assert property (p_flag_rd_clear) else $error("flag not cleared");

    property p_x_rd_clear;
        req.rd && req.addr == ADDR_X_DISPLACEMENT && !i_frame.valid && !q.rst_all
        |=> q.dx == 8'sh00 && q.rdata == $past(q.dx);
    endproperty
    a_x_rd_clear: assert property (p_x_rd_clear) else $error("x read clear wrong");

    property p_y_rd_clear;
        req.rd && req.addr == ADDR_Y_DISPLACEMENT && !i_frame.valid && !q.rst_all
        |=> q.dy == 8'sh00 && q.rdata == $past(q.dy);
    endproperty
    a_y_rd_clear: assert property (p_y_rd_clear) else $error("y read clear wrong");

    property p_x_sat;
        q.dx == 8'sh7f && dxs >= 8'sh00 && !req.rd && !req.wr && !q.rst_all
        |=> q.dx == 8'sh7f;
    endproperty
    a_x_sat: assert property (p_x_sat) else $error("x displacement wrapped");

    property p_status_read;
        req.rd && req.addr == ADDR_MOTION_STATUS && !q.rst_all
        |=> q.rdata == {$past(q.movement_flag), 7'h00};
    endproperty
    a_status_read: assert property (p_status_read) else $error("motion status read wrong");

    property p_quality_cap;
        q.quality <= QUALITY_MAX;
    endproperty
    a_quality_cap: assert property (p_quality_cap) else $error("quality above cap");

    property p_quality_frame;
        i_frame.valid && !q.rst_all
        |=> q.quality == QUALITY_MAX || q.quality == $past(i_frame.features[8:1]);
    endproperty
    a_quality_frame: assert property (p_quality_frame) else $error("quality not taken");

    property p_sum_cap;
        q.acc <= 15'd28575 |-> q.sum_reg <= 8'd223;
    endproperty
    a_sum_cap: assert property (p_sum_cap) else $error("pixel sum above cap");

    property p_grab_read;
        req.rd && req.addr == ADDR_CAPTURE_PORT && q.grab_valid && !q.rst_all
        |=> q.rdata[GRAB_VALID_BIT] && !q.grab_valid &&
            q.grab_cnt == (($past(q.grab_cnt) == LAST_PIXEL) ? 8'h00 :
                           $past(q.grab_cnt) + 8'h01);
    endproperty
    a_grab_read: assert property (p_grab_read) else $error("grab read did not advance");

    property p_grab_empty;
        rd_of && !q.grab_valid && !q.rst_all
        |=> !q.rdata[GRAB_VALID_BIT] && $stable(q.grab_cnt);
    endproperty
    a_grab_empty: assert property (p_grab_empty) else $error("empty grab read wrong");

    property p_grab_write;
        wr_of && !q.rst_all |=> q.grab_cnt == 8'h00 && !q.grab_valid
        ##1 (!q.grab_valid || $past(i_pix.first));
    endproperty
    a_grab_write: assert property (p_grab_write) else $error("grab write did not rearm");

    property p_chip_reset;
        req.wr && req.addr == ADDR_CHIP_RESET && req.wdata == CHIP_RESET_KEY
        |=> q.rst_all ##1 (!q.movement_flag && q.dx == 8'sh00 && q.grab_cnt == 8'h00);
    endproperty
    a_chip_reset: assert property (p_chip_reset) else $error("chip reset not taken");

    // Grabber holding, capture and frame statistics
    property p_grab_hold;
        q.grab_valid && !rd_of && !wr_of && !q.rst_all
        |=> q.grab_valid && $stable(q.grab_pix);
    endproperty
    a_grab_hold: assert property (p_grab_hold) else $error("held pixel lost");

    property p_grab_first;
        i_pix.valid && i_pix.first && !q.grab_valid && q.grab_cnt == 8'h00 &&
        !wr_of && !q.rst_all |=> q.grab_valid && q.grab_pix == $past(i_pix.value);
    endproperty
    a_grab_first: assert property (p_grab_first) else $error("pixel 0 not captured");

    property p_exposure_hold;
        !i_pix.valid && !q.rst_all |=> $stable(q.shutter);
    endproperty
    a_exposure_hold: assert property (p_exposure_hold) else $error("exposure moved");

    property p_bright_order;
        q.maxp >= q.minp;
    endproperty
    a_bright_order: assert property (p_bright_order) else $error("max below min");
endmodule
`default_nettype wire

// ==== serial_ctl_model.sv ====
// Controller model that runs register transfers over the four-wire serial port
`timescale 1ns/1ps
`default_nettype none
module serial_ctl_model (
    input  wire logic i_core_clk,
    input  wire logic i_miso,
    output logic      o_ncs_n,
    output logic      o_sclk,
    output logic      o_mosi
);
    initial begin
        o_ncs_n = 1'b1;
        o_sclk  = 1'b1;
        o_mosi  = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // Data set on falling sclk, taken on rising; 8-cycle phases keep the sync margin
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] word;
        word = {wr, addr, wdata};
        rdata = 8'h00;
        o_ncs_n = 1'b0;
        tick(8);
        for (int i = 15; i >= 0; i--) begin
            // Extra gap lets the read answer reach the pin
            if (i == 7) begin
                tick(16);
            end
            o_sclk = 1'b0;
            o_mosi = word[i];
            tick(8);
            if (i < 8) begin
                rdata[i] = i_miso;
            end
            o_sclk = 1'b1;
            tick(8);
        end
        o_ncs_n = 1'b1;
        // Released line must not keep the last bit
        o_mosi = ~o_mosi;
        tick(12);
    endtask
endmodule
`default_nettype wire

// ==== motion_and_image_readout_regs_tb.sv ====
// Self-checking testbench for the motion and image readout registers
`timescale 1ns/1ps
`default_nettype none
module motion_and_image_readout_regs_tb;
    import sensor_readout_pkg::*;
    logic          core_clk, srst, pin_n, res_high, ncs_n, sclk, mosi, miso;
    logic [15:0]   exposure;
    logic [7:0]    rd;
    frame_result_t frame;
    pixel_t        pix;
    int            errors, samples_checked, cycles;

    motion_and_image_readout_regs motion_and_image_readout_regs_inst (
        .i_core_clk(core_clk), .i_srst(srst), .i_hardware_reset_pin_n(pin_n),
        .i_ncs_n(ncs_n), .i_sclk(sclk), .i_mosi(mosi), .i_res_high(res_high),
        .i_frame(frame), .i_pix(pix), .o_miso(miso), .o_exposure(exposure));

    serial_ctl_model serial_ctl_model_inst (
        .i_core_clk(core_clk), .i_miso(miso), .o_ncs_n(ncs_n), .o_sclk(sclk), .o_mosi(mosi));

    always #10 core_clk = ~core_clk;

    task automatic report_and_stop();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        serial_ctl_model_inst.xfer(1'b0, a, 8'h00, rd);
        check({8'h00, rd}, {8'h00, exp}, $sformatf("register %h", a));
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        serial_ctl_model_inst.xfer(1'b1, a, d, rd);
    endtask

    task automatic send_frame(input logic [7:0] dx, input logic [7:0] dy, input logic [8:0] ft);
        @(posedge core_clk);
        #1;
        frame = '{valid: 1'b1, dx: dx, dy: dy, features: ft};
        @(posedge core_clk);
        #1;
        frame.valid = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic send_pixels(input logic [6:0] v0, input logic [6:0] step);
        @(posedge core_clk);
        #1;
        for (int i = 0; i < 225; i++) begin
            pix = '{valid: 1'b1, first: (i == 0), value: 7'(v0 + step * i)};
            @(posedge core_clk);
            #1;
        end
        pix.valid = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset_values();
        check(exposure, SHUTTER_RESET, "exposure after reset");
        for (int a = 2; a <= 12; a++) begin
            rd_chk(7'(a), REG_RESET);
        end
    endtask

    task automatic t_motion();
        send_frame(8'h05, 8'hfd, 9'h000);
        rd_chk(ADDR_MOTION_STATUS, 8'h80);
        rd_chk(ADDR_X_DISPLACEMENT, 8'h05);
        rd_chk(ADDR_Y_DISPLACEMENT, 8'hfd);
        rd_chk(ADDR_X_DISPLACEMENT, 8'h00);
        rd_chk(ADDR_MOTION_STATUS, 8'h00);
    endtask

    task automatic t_scale_saturate();
        res_high = 1'b0;
        send_frame(8'h07, 8'hf9, 9'h000);
        rd_chk(ADDR_MOTION_STATUS, 8'h80);
        rd_chk(ADDR_X_DISPLACEMENT, 8'h03);
        rd_chk(ADDR_Y_DISPLACEMENT, 8'hfc);
        res_high = 1'b1;
        send_frame(8'h64, 8'h9c, 9'h000);
        send_frame(8'h64, 8'h9c, 9'h000);
        rd_chk(ADDR_MOTION_STATUS, 8'h80);
        rd_chk(ADDR_X_DISPLACEMENT, 8'h7f);
        rd_chk(ADDR_Y_DISPLACEMENT, 8'h80);
    endtask

    task automatic t_write_clear();
        send_frame(8'h04, 8'h04, 9'h000);
        wr(ADDR_MOTION_STATUS, 8'hff);
        rd_chk(ADDR_MOTION_STATUS, 8'h00);
        rd_chk(ADDR_X_DISPLACEMENT, 8'h00);
        rd_chk(ADDR_Y_DISPLACEMENT, 8'h00);
    endtask

    task automatic t_quality();
        send_frame(8'h00, 8'h00, 9'h1ff);
        rd_chk(ADDR_SURFACE_QUALITY, QUALITY_MAX);
        send_frame(8'h00, 8'h00, 9'h015);
        rd_chk(ADDR_SURFACE_QUALITY, 8'h0a);
    endtask

    task automatic t_stats_exposure();
        int sm;
        sm = 0;
        for (int i = 0; i < 225; i++) begin
            sm += i % 128;
        end
        send_pixels(7'h00, 7'h01);
        rd_chk(ADDR_BRIGHTEST, 8'h7f);
        rd_chk(ADDR_DARKEST, 8'h00);
        rd_chk(ADDR_BRIGHTNESS_SUM, 8'(sm >> SUM_LSB));
        check(exposure, SHUTTER_RESET, "exposure floor");
        send_pixels(7'h0a, 7'h00);
        rd_chk(ADDR_BRIGHTEST, 8'h0a);
        rd_chk(ADDR_DARKEST, 8'h0a);
        rd_chk(ADDR_BRIGHTNESS_SUM, 8'((225 * 10) >> SUM_LSB));
        check(exposure, SHUTTER_STEP, "exposure step up");
        rd_chk(ADDR_EXPOSURE_HIGH, SHUTTER_STEP[15:8]);
        rd_chk(ADDR_EXPOSURE_LOW, SHUTTER_STEP[7:0]);
    endtask

    task automatic t_chip_reset();
        send_frame(8'h02, 8'h02, 9'h040);
        wr(ADDR_CHIP_RESET, 8'h5b);
        check(exposure, SHUTTER_STEP, "exposure after wrong key");
        wr(ADDR_CHIP_RESET, CHIP_RESET_KEY);
        check(exposure, SHUTTER_RESET, "exposure after chip reset");
        rd_chk(ADDR_MOTION_STATUS, 8'h00);
        rd_chk(ADDR_SURFACE_QUALITY, 8'h00);
        send_frame(8'h01, 8'h01, 9'h000);
        pin_n = 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        pin_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        rd_chk(ADDR_MOTION_STATUS, 8'h00);
    endtask

    task automatic t_grab();
        wr(ADDR_CAPTURE_PORT, 8'h00);
        serial_ctl_model_inst.xfer(1'b0, ADDR_CAPTURE_PORT, 8'h00, rd);
        check({15'h0000, rd[GRAB_VALID_BIT]}, 16'h0000, "grab empty");
        send_pixels(7'h14, 7'h01);
        rd_chk(ADDR_CAPTURE_PORT, 8'h94);
        serial_ctl_model_inst.xfer(1'b0, ADDR_CAPTURE_PORT, 8'h00, rd);
        check({15'h0000, rd[GRAB_VALID_BIT]}, 16'h0000, "one grab per frame");
        send_pixels(7'h14, 7'h01);
        rd_chk(ADDR_CAPTURE_PORT, 8'h95);
        wr(ADDR_CAPTURE_PORT, 8'h33);
        send_pixels(7'h14, 7'h01);
        rd_chk(ADDR_CAPTURE_PORT, 8'h94);
    endtask

    initial begin
        core_clk = 1'b0;
        srst = 1'b1;
        pin_n = 1'b1;
        res_high = 1'b1;
        frame = '0;
        pix = '0;
        repeat (5) @(posedge core_clk);
        #1;
        srst = 1'b0;
        t_reset_values();
        t_motion();
        t_scale_saturate();
        t_write_clear();
        t_quality();
        t_stats_exposure();
        t_chip_reset();
        t_grab();
        report_and_stop();
    end
endmodule
`default_nettype wire
